// File: shared/tdps_pkg.sv
package tdps_pkg;

  // Register map, byte addresses; the auxiliary set repeats at SEQ_STRIDE
  localparam logic [3:0] OFF_CONTROL = 4'h0;
  localparam logic [3:0] OFF_TABLE_CONTROL = 4'h4;
  localparam logic [3:0] OFF_TABLE_ENTRY = 4'h8;
  localparam logic [3:0] OFF_STATUS = 4'hc;
  localparam logic [7:0] SEQ_STRIDE = 8'h10;
  localparam int NUM_SEQ = 2;

  localparam int TABLE_DEPTH = 256;
  localparam int IDX_W = 8;
  localparam int COUNT_W = 10;

  // Run command encodings
  localparam logic [2:0] CMD_IDLE = 3'h0;
  localparam logic [2:0] CMD_RUN = 3'h1;
  localparam logic [2:0] CMD_JUMP = 3'h2;
  localparam logic [2:0] CMD_STOP = 3'h3;
  localparam logic [2:0] CMD_ABORT = 3'h4;

  // Trigger source select encodings
  localparam logic [3:0] TSEL_TRIG = 4'h0;
  localparam logic [3:0] TSEL_ENC_A = 4'h1;
  localparam logic [3:0] TSEL_ENC_B = 4'h2;
  localparam logic [3:0] TSEL_ENC_Q = 4'h3;
  localparam logic [3:0] TSEL_GATED = 4'h4;
  localparam logic [3:0] TSEL_ENC_DIV = 4'h5;

  // Entry execution conditions
  localparam logic [2:0] COND_IMMEDIATE = 3'h0;
  localparam logic [2:0] COND_RISE = 3'h1;
  localparam logic [2:0] COND_FALL = 3'h2;
  localparam logic [2:0] COND_ANY_EDGE = 3'h3;
  localparam logic [2:0] COND_HIGH = 3'h4;
  localparam logic [2:0] COND_LOW = 3'h5;

  // Time units selected by the resolution field
  localparam logic [1:0] RES_100NS = 2'h0;
  localparam logic [1:0] RES_100US = 2'h1;
  localparam logic [1:0] RES_100MS = 2'h2;
  localparam logic [1:0] RES_100S = 2'h3;

  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 100;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UNIT_100US_NS = 100000;
  localparam int UNIT_RATIO = UNIT_100US_NS / TICK_NS;

  // Reset values
  localparam logic [3:0] IDLE_LEVEL_RST = 4'h0;
  localparam logic [7:0] JUMP_IDX_RST = 8'h00;
  localparam logic [3:0] TRIG_SEL_RST = 4'h0;

  typedef struct packed {
    logic [3:0] trig_sel;
    logic [3:0] rsv_27_24;
    logic [7:0] jump_idx;
    logic [7:0] rsv_15_8;
    logic [3:0] idle_level;
    logic rsv_3;
    logic [2:0] run_cmd;
  } tdps_ctrl_t;

  typedef struct packed {
    logic seq_end;
    logic terminate;
    logic [2:0] condition;
    logic [9:0] count;
    logic rsv_16;
    logic [3:0] level;
    logic [1:0] resolution;
    logic [1:0] rsv_9_8;
    logic [7:0] next_idx;
  } tdps_entry_t;

  typedef struct packed {
    logic [21:0] rsv_31_10;
    logic waiting;
    logic running;
    logic [7:0] cur_idx;
  } tdps_status_t;

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_WAIT, ST_PULSE} tdps_state_t;

endpackage

// File: src/tdps_table_ram.sv
`timescale 1ns/10ps
module tdps_table_ram
  import tdps_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_addr,
  input wire tdps_entry_t wr_data,
  input wire logic [IDX_W-1:0] rd_addr,
  output tdps_entry_t rd_data
);

  tdps_entry_t mem [TABLE_DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read-first; the address is tracked outside so stale data is never used blindly
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// File: src/tdps_timebase.sv
`timescale 1ns/10ps
module tdps_timebase
  import tdps_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic [1:0] unit_sel,
  output logic unit_tick
);

  logic [3:0] pre;
  logic [9:0] c_us;
  logic [9:0] c_ms;
  logic [9:0] c_s;
  logic t_ns;
  logic t_us;
  logic t_ms;
  logic t_s;

  assign t_ns = (pre == 4'(TICK_CYCLES - 1));
  assign t_us = t_ns && (c_us == 10'(UNIT_RATIO - 1));
  assign t_ms = t_us && (c_ms == 10'(UNIT_RATIO - 1));
  assign t_s = t_ms && (c_s == 10'(UNIT_RATIO - 1));

  // Cascade restarts with each sub-pulse so its length carries no phase error
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre <= 4'h0;
      c_us <= 10'h000;
      c_ms <= 10'h000;
      c_s <= 10'h000;
    end else if (restart) begin
      pre <= 4'h0;
      c_us <= 10'h000;
      c_ms <= 10'h000;
      c_s <= 10'h000;
    end else begin
      pre <= t_ns ? 4'h0 : pre + 4'h1;
      if (t_ns) c_us <= t_us ? 10'h000 : c_us + 10'h001;
      if (t_us) c_ms <= t_ms ? 10'h000 : c_ms + 10'h001;
      if (t_ms) c_s <= t_s ? 10'h000 : c_s + 10'h001;
    end
  end

  assign unit_tick = (unit_sel == RES_100NS) ? t_ns :
                     (unit_sel == RES_100US) ? t_us :
                     (unit_sel == RES_100MS) ? t_ms : t_s;

endmodule

// File: src/tdps_top.sv
// Notes on behaviour
// - Each sequencer owns a table of 256 entries, one sub-pulse each.
// - Software selects an entry index, then writes its contents through a data register.
// - An entry selects 100 s, 100 ms, 100 us or 100 ns units.
// - Duration equals count times unit; counts run 1 to 1023.
// - Consecutive entries follow back to back without gap or glitch.
// - Each entry sets the level of every channel for its whole duration.
// - Each entry links to the next entry, permitting branches and loops.
// - Immediate entries start their sub-pulse as soon as reached.
// - Trigger entries wait for the selected trigger event before pulsing.
// - In trigger mode a trigger event yields one pulse only if an entry is waiting for it; others are ignored.
// - An entry produces at most one sub-pulse per execution.
// - Main and auxiliary sequencers are identical; auxiliary registers answer the bus only when AUX_PRESENT is set.
// - Jump switches sequences at the end of a marked entry, undisturbed.
// - Trigger waits may occur at any entry in a train.
// - Commands: idle, run, jump at end mark, stop at end mark, abort.
// - Trigger select picks trigger, encoders, quadrature, gated trigger or divider.
// - Next index used only without terminate; terminate ends execution after the entry.
// - While idle, each channel drives its programmed idle level.
`timescale 1ns/10ps
module tdps_top
  import tdps_pkg::*;
#(
  parameter bit AUX_PRESENT = 1'b1
)
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic TRIG,
  input wire logic ENC_A,
  input wire logic ENC_B,
  input wire logic ENC_Q,
  input wire logic ENC_DIV,
  output logic [3:0] MAIN_CT,
  output logic [3:0] AUX_CT
);

  wire [3:0] bus_inst = PADDR[7:4];
  wire [3:0] bus_off = PADDR[3:0];
  wire inst_ok = (bus_inst == 4'h0) || (AUX_PRESENT && bus_inst == 4'h1);
  wire addr_ok = inst_ok && (PADDR[1:0] == 2'h0);
  wire setup_phase = PSEL && !PENABLE;
  wire wr_en = PSEL && PENABLE && PWRITE && addr_ok;
  wire tdps_ctrl_t wr_ctrl_word = tdps_ctrl_t'(PWDATA);

  logic [31:0] reg_word [NUM_SEQ];
  logic [31:0] next_prdata;
  logic [3:0] ct [NUM_SEQ];

  assign next_prdata = addr_ok ? reg_word[bus_inst[0]] : 32'h0000_0000;
  assign PREADY = 1'b1;

  // Read data and error are captured in the setup cycle so they stand through access
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (setup_phase) begin
      PRDATA <= PWRITE ? 32'h0000_0000 : next_prdata;
      PSLVERR <= !addr_ok;
    end
  end

  assign MAIN_CT = ct[0];
  assign AUX_CT = ct[1];

  genvar g;
  generate
    for (g = 0; g < NUM_SEQ; g++) begin : g_seq
      wire hit = wr_en && (bus_inst == 4'(g));
      wire wr_ctrl = hit && (bus_off == OFF_CONTROL);
      wire wr_tctl = hit && (bus_off == OFF_TABLE_CONTROL);
      wire wr_entry = hit && (bus_off == OFF_TABLE_ENTRY);
      wire cmd_start = wr_ctrl && (wr_ctrl_word.run_cmd == CMD_RUN);
      wire cmd_abort = wr_ctrl && (wr_ctrl_word.run_cmd == CMD_ABORT);

      logic [2:0] run_cmd;
      logic [3:0] idle_level;
      logic [7:0] jump_idx;
      logic [3:0] trig_sel;
      logic [7:0] tbl_idx;
      tdps_entry_t entry_shadow;

      tdps_state_t state;
      tdps_entry_t cur;
      logic [7:0] cur_idx;
      logic [9:0] remaining;
      logic [3:0] level;
      logic [7:0] rd_addr_q;
      logic trig_prev;

      tdps_state_t next_state;
      tdps_entry_t next_cur;
      logic [7:0] next_idx;
      logic [9:0] next_remaining;
      logic [3:0] next_level;
      logic [2:0] next_cmd;
      logic restart;

      tdps_entry_t rd_data;
      tdps_status_t status;
      logic unit_tick;

      wire [7:0] follow_idx = (cur.seq_end && run_cmd == CMD_JUMP) ? jump_idx :
                              cur.next_idx;
      wire [7:0] rd_addr = (state == ST_FETCH || state == ST_IDLE) ? cur_idx : follow_idx;
      wire pulse_end = (state == ST_PULSE) && unit_tick && (remaining <= 10'h001);
      wire trig_now = (trig_sel == TSEL_TRIG) ? TRIG :
                      (trig_sel == TSEL_ENC_A) ? ENC_A :
                      (trig_sel == TSEL_ENC_B) ? ENC_B :
                      (trig_sel == TSEL_ENC_Q) ? ENC_Q :
                      (trig_sel == TSEL_GATED) ? (TRIG && ENC_B) :
                      (trig_sel == TSEL_ENC_DIV) ? ENC_DIV : 1'b0;
      wire trig_rise = trig_now && !trig_prev;
      wire trig_fall = !trig_now && trig_prev;
      wire trig_fire = (cur.condition == COND_FALL) ? trig_fall :
                       (cur.condition == COND_ANY_EDGE) ? (trig_rise || trig_fall) :
                       (cur.condition == COND_HIGH) ? trig_now :
                       (cur.condition == COND_LOW) ? !trig_now : trig_rise;

      tdps_table_ram u_ram (
        .clk(CLK),
        .rst_n(RST_N),
        .wr_en(wr_entry),
        .wr_addr(tbl_idx),
        .wr_data(tdps_entry_t'(PWDATA)),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
      );

      tdps_timebase u_tb (
        .clk(CLK),
        .rst_n(RST_N),
        .restart(restart),
        .unit_sel(cur.resolution),
        .unit_tick(unit_tick)
      );

      assign status = '{rsv_31_10: 22'h0, waiting: (state == ST_WAIT),
                        running: (state != ST_IDLE), cur_idx: cur_idx};
      assign reg_word[g] = (bus_off == OFF_CONTROL) ?
                             {trig_sel, 4'h0, jump_idx, 8'h00, idle_level, 1'b0, run_cmd} :
                           (bus_off == OFF_TABLE_CONTROL) ? {24'h00_0000, tbl_idx} :
                           (bus_off == OFF_TABLE_ENTRY) ? 32'(entry_shadow) :
                           32'(status);

      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          idle_level <= IDLE_LEVEL_RST;
          jump_idx <= JUMP_IDX_RST;
          trig_sel <= TRIG_SEL_RST;
        end else if (wr_ctrl) begin
          idle_level <= wr_ctrl_word.idle_level;
          jump_idx <= wr_ctrl_word.jump_idx;
          trig_sel <= wr_ctrl_word.trig_sel;
        end
      end

      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          tbl_idx <= 8'h00;
          entry_shadow <= '0;
        end else begin
          if (wr_tctl) tbl_idx <= PWDATA[7:0];
          if (wr_entry) entry_shadow <= tdps_entry_t'(PWDATA);
        end
      end

      // Sequencing; software command writes win over hardware command updates
      always_comb begin
        next_state = state;
        next_cur = cur;
        next_idx = cur_idx;
        next_remaining = remaining;
        next_level = level;
        next_cmd = wr_ctrl ? wr_ctrl_word.run_cmd : run_cmd;
        restart = 1'b0;
        if (state == ST_PULSE && unit_tick) begin
          next_remaining = remaining - 10'h001;
        end
        if (cmd_abort) begin
          next_state = ST_IDLE;
          next_cmd = CMD_IDLE;
        end else if (cmd_start) begin
          next_state = ST_FETCH;
          next_idx = wr_ctrl_word.jump_idx;
          next_level = wr_ctrl_word.idle_level;
        end else begin
          unique case (state)
            ST_IDLE: begin
            end
            ST_FETCH: begin
              if (rd_addr_q == cur_idx) begin
                next_cur = rd_data;
                if (rd_data.condition == COND_IMMEDIATE) begin
                  next_state = ST_PULSE;
                  next_level = rd_data.level;
                  next_remaining = rd_data.count;
                  restart = 1'b1;
                end else begin
                  next_state = ST_WAIT;
                end
              end
            end
            ST_WAIT: begin
              if (trig_fire) begin
                next_state = ST_PULSE;
                next_level = cur.level;
                next_remaining = cur.count;
                restart = 1'b1;
              end
            end
            ST_PULSE: begin
              if (pulse_end) begin
                if (cur.terminate) begin
                  next_state = ST_IDLE;
                  if (!wr_ctrl) next_cmd = CMD_IDLE;
                end else if (cur.seq_end && run_cmd == CMD_STOP) begin
                  next_state = ST_IDLE;
                  if (!wr_ctrl) next_cmd = CMD_IDLE;
                end else begin
                  if (cur.seq_end && run_cmd == CMD_JUMP && !wr_ctrl) begin
                    next_cmd = CMD_RUN;
                  end
                  next_idx = follow_idx;
                  if (rd_addr_q != follow_idx) begin
                    // Link changed in the last cycle: refetch, holding the level
                    next_state = ST_FETCH;
                  end else begin
                    next_cur = rd_data;
                    if (rd_data.condition == COND_IMMEDIATE) begin
                      next_level = rd_data.level;
                      next_remaining = rd_data.count;
                      restart = 1'b1;
                    end else begin
                      next_state = ST_WAIT;
                    end
                  end
                end
              end
            end
          endcase
        end
      end

      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          state <= ST_IDLE;
          run_cmd <= CMD_IDLE;
          cur <= '0;
          cur_idx <= 8'h00;
          remaining <= 10'h000;
          level <= IDLE_LEVEL_RST;
          rd_addr_q <= 8'h00;
          trig_prev <= 1'b0;
        end else begin
          state <= next_state;
          run_cmd <= next_cmd;
          cur <= next_cur;
          cur_idx <= next_idx;
          remaining <= next_remaining;
          level <= next_level;
          rd_addr_q <= rd_addr;
          trig_prev <= trig_now;
        end
      end

      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          ct[g] <= IDLE_LEVEL_RST;
        end else begin
          ct[g] <= (next_state == ST_IDLE) ? idle_level : next_level;
        end
      end
    end
  endgenerate

endmodule

// File: tb/tdps_top_assertions.sv
`timescale 1ns/10ps
module tdps_checker
  import tdps_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [3:0] MAIN_CT,
  input wire logic [3:0] AUX_CT
);
  logic [3:0] main_idle;
  logic [3:0] aux_idle;
  wire logic wr_done = PSEL && PENABLE && PWRITE;

  // Shadow of the idle levels so an abort can be judged against what software last wrote
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      main_idle <= 4'h0;
      aux_idle <= 4'h0;
    end else if (wr_done && PADDR == 8'h00) begin
      main_idle <= PWDATA[7:4];
    end else if (wr_done && PADDR == 8'h10) begin
      aux_idle <= PWDATA[7:4];
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_ready_high: assert property (PREADY)
    else $error("ready dropped");
  a_reset_idle: assert property ($rose(RST_N) |-> MAIN_CT == 4'h0 && AUX_CT == 4'h0)
    else $error("channels not idle after reset");
  a_abort_main: assert property (
    wr_done && PADDR == 8'h00 && PWDATA[2:0] == CMD_ABORT |-> ##[1:3] MAIN_CT == main_idle)
    else $error("main abort did not restore idle level");
  a_abort_aux: assert property (
    wr_done && PADDR == 8'h10 && PWDATA[2:0] == CMD_ABORT |-> ##[1:3] AUX_CT == aux_idle)
    else $error("aux abort did not restore idle level");
  a_slot_error: assert property (PSEL && !PENABLE && PADDR[7:4] > 4'h1 |=> PSLVERR)
    else $error("unmapped slot not refused");
  a_align_error: assert property (PSEL && !PENABLE && PADDR[1:0] != 2'h0 |=> PSLVERR)
    else $error("unaligned access not refused");
  a_mapped_ok: assert property (
    PSEL && !PENABLE && PADDR[7:4] <= 4'h1 && PADDR[1:0] == 2'h0 |=> !PSLVERR)
    else $error("mapped access refused");
  a_error_data: assert property (PSEL && PENABLE && PSLVERR |-> PRDATA == 32'h0)
    else $error("refused access returned data");
  a_write_data: assert property (PSEL && !PENABLE && PWRITE |=> PRDATA == 32'h0)
    else $error("write returned data");
endmodule

bind tdps_top tdps_checker u_checker (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .MAIN_CT(MAIN_CT), .AUX_CT(AUX_CT));

// File: tb/tdps_trigger_source.sv
`timescale 1ns/10ps
module tdps_trigger_source (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] fire,
  output logic [4:0] lines
);
  logic [4:0] hold;
  logic [1:0] left;

  // Routed sources are always driven; they fall back low after a 3 cycle pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold <= 5'h00;
      left <= 2'h0;
    end else if (fire != 5'h00) begin
      hold <= fire;
      left <= 2'h3;
    end else if (left != 2'h0) begin
      left <= left - 2'h1;
    end
  end

  assign lines = (left != 2'h0) ? hold : 5'h00;
endmodule

// File: tb/tb_table_driven_pulse_sequencer.sv
`timescale 1ns/10ps
module tb_table_driven_pulse_sequencer;
  import tdps_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, base;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] fire, line;
  logic [3:0] main_ct, aux_ct, idle, lv_a, lv_b, seen;
  logic [4:0] trig_mask [6];
  logic [9:0] cnt [3];
  int n_fail, comparisons, n, seed;
  tdps_ctrl_t ctl;
  tdps_entry_t ent;

  assign seen = base[4] ? aux_ct : main_ct;

  tdps_top u_dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TRIG(line[0]), .ENC_A(line[1]), .ENC_B(line[2]), .ENC_Q(line[3]), .ENC_DIV(line[4]),
    .MAIN_CT(main_ct), .AUX_CT(aux_ct));
  tdps_trigger_source u_src (.clk(clk), .rst_n(rst_n), .fire(fire), .lines(line));

  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic put(input logic [7:0] i, input logic [7:0] nx, input logic [3:0] lv,
      input logic [9:0] c, input logic [2:0] cd, input logic [1:0] rs, input logic t,
      input logic se);
    ent = '0;
    ent.next_idx = nx;
    ent.level = lv;
    ent.count = c;
    ent.condition = cd;
    ent.resolution = rs;
    ent.terminate = t;
    ent.seq_end = se;
    apb(1'b1, base | OFF_TABLE_CONTROL, {24'h0, i});
    apb(1'b1, base | OFF_TABLE_ENTRY, ent);
    apb(1'b0, base | OFF_TABLE_ENTRY, 32'h0);
    check("table entry", rd, ent);
  endtask

  task automatic cmd(input logic [2:0] c, input logic [7:0] j, input logic [3:0] ts);
    ctl = '0;
    ctl.run_cmd = c;
    ctl.idle_level = idle;
    ctl.jump_idx = j;
    ctl.trig_sel = ts;
    apb(1'b1, base | OFF_CONTROL, ctl);
  endtask

  // Counts whole cycles of one level, sampled away from the launching edge
  task automatic dur(input logic [3:0] lv);
    n = 0;
    while (seen !== lv) @(negedge clk);
    while (seen === lv) begin
      n++;
      @(negedge clk);
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    // About 64k cycles are needed; the limit keeps a hang under 80k cycles
    #800000;
    n_fail++;
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fire = 5'h00;
    base = 8'h00;
    seed = 32'h7034c5eb;
    trig_mask = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h05, 5'h10};
    cnt = '{10'd1, 10'd1023, 10'd1};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    check("reset channels", {aux_ct, main_ct}, 8'h00);
    apb(1'b0, 8'h20, 32'h0);
    check("slot error", err, 1'b1);
    apb(1'b0, 8'h06, 32'h0);
    check("align error", err, 1'b1);
    check("align data", rd, 32'h0);
    $display("bus refusal test done");
    for (int s = 0; s < 2; s++) begin
      base = s ? SEQ_STRIDE : 8'h00;
      idle = 4'($random(seed));
      lv_a = ~idle;
      lv_b = idle ^ 4'h5;
      apb(1'b0, base | OFF_CONTROL, 32'h0);
      check("control reset", rd, 32'h0);
      cmd(CMD_IDLE, 8'h00, TSEL_TRIG);
      apb(1'b0, base | OFF_CONTROL, 32'h0);
      check("control readback", rd, ctl);
      repeat (3) @(negedge clk);
      check("idle level", seen, idle);
      cnt[2] = 10'd1 + 10'($random(seed) & 63);
      for (int k = 0; k < 3; k++) begin
        put(8'h00, 8'h05, lv_a, cnt[k], COND_IMMEDIATE, RES_100NS, 1'b0, 1'b0);
        put(8'h05, 8'h00, lv_b, 10'd2, COND_IMMEDIATE, k ? RES_100NS : RES_100US, 1'b1, 1'b0);
        cmd(CMD_RUN, 8'h00, TSEL_TRIG);
        dur(lv_a);
        check("first length", n, cnt[k] * TICK_CYCLES);
        check("seamless", seen, lv_b);
        dur(lv_b);
        check("second length", n, (k ? 2 : 2 * UNIT_RATIO) * TICK_CYCLES);
        check("terminated", seen, idle);
      end
      put(8'h0a, 8'h0b, lv_a, 10'd2, COND_IMMEDIATE, RES_100NS, 1'b0, 1'b0);
      for (int t = 0; t < 6; t++) begin
        put(8'h0b, 8'h00, lv_b, 10'd1, 3'(t % 4 + 1), RES_100NS, 1'b1, 1'b0);
        cmd(CMD_RUN, 8'h0a, 4'(t));
        repeat (60) @(negedge clk);
        check("trigger wait", seen, lv_a);
        apb(1'b0, base | OFF_STATUS, 32'h0);
        check("wait status", rd, 32'h0000_030b);
        @(posedge clk);
        fire <= trig_mask[t];
        @(posedge clk);
        fire <= 5'h00;
        dur(lv_b);
        check("one shot", n, TICK_CYCLES);
        check("after shot", seen, idle);
      end
      // Sources idle low, so a low-level condition fires without any pulse from the model
      put(8'h0b, 8'h00, lv_b, 10'd1, COND_LOW, RES_100NS, 1'b1, 1'b0);
      cmd(CMD_RUN, 8'h0a, TSEL_TRIG);
      dur(lv_b);
      check("low level shot", n, TICK_CYCLES);
      check("after low shot", seen, idle);
      put(8'h14, 8'h14, lv_a, 10'd1, COND_IMMEDIATE, RES_100NS, 1'b0, 1'b1);
      for (int c = 2; c < 5; c++) begin
        cmd(CMD_RUN, 8'h14, TSEL_TRIG);
        repeat (35) @(posedge clk);
        cmd(3'(c), 8'h05, TSEL_TRIG);
        if (c == 2) begin
          dur(lv_b);
          check("jump target", n, 2 * TICK_CYCLES);
        end
        repeat (15) @(negedge clk);
        check("stopped", seen, idle);
        apb(1'b0, base | OFF_CONTROL, 32'h0);
        check("command idle", rd[2:0], CMD_IDLE);
      end
      $display("instance %0d sequence tests done", s);
    end
    wrap_up();
  end
endmodule
